// >>> rtl/tam_top.sv
// Overview of operation
// - Set bit in alarm 1 gate blocks that channel's event from alarm 1.
// - Set bit in alarm 2 gate blocks that channel's event from alarm 2.
// - Set bit in alarm 3 gate blocks that channel's event from alarm 3.
// - Gate bit 0 is local, bits 1 to 4 remotes 1 to 4, all writable.
// - Gate register bits 7 to 5 always read zero.
// - Local threshold is unsigned 0 to 127 degrees, one degree per step.
// - Local reading compared with local threshold gives local event.
// - Local threshold bit 7 reads zero and cannot be written.
// - Remote thresholds are full 8-bit unsigned, 0 to 255 degrees.
// - Remotes 1 and 2 set A thresholds serve only alarm 1.
// - Remotes 1 and 2 set B thresholds serve alarms 2 and 3.
// - Remotes 3, 4 and local use one threshold for all three alarms.
// - Flag sets at reading >= limit, clears below limit minus hysteresis.
// - Alarm active while any unmasked flag set, inactive when all clear.
// - One 5-bit hysteresis lowers every limit, reset value ten degrees.
`timescale 1ns/10ps
`default_nettype none
`include "tam_consts.svh"

module tam_top (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset,
  // Register access from the serial engine
  input  wire logic               reg_wr_en,
  input  wire logic               reg_rd_en,
  input  wire tam_pkg::tam_byte_t reg_addr,
  input  wire tam_pkg::tam_byte_t reg_wdata,
  output tam_pkg::tam_byte_t      reg_rdata_r,
  output logic                    reg_rd_valid_r,
  // Conversion results, whole degrees
  input  wire tam_pkg::tam_chan_vec_t conv_done,
  input  wire tam_pkg::tam_byte_t local_temp,
  input  wire tam_pkg::tam_byte_t remote1_temp,
  input  wire tam_pkg::tam_byte_t remote2_temp,
  input  wire tam_pkg::tam_byte_t remote3_temp,
  input  wire tam_pkg::tam_byte_t remote4_temp,
  // Per-alarm channel flags for the status registers
  output tam_pkg::tam_chan_vec_t  alarm1_over_flags,
  output tam_pkg::tam_chan_vec_t  alarm2_over_flags,
  output tam_pkg::tam_chan_vec_t  alarm3_over_flags,
  // Alarm pins, active low
  output logic                    alarm_out_1_n_r,
  output logic                    alarm_out_2_n_r,
  output logic                    alarm_out_3_n_r
);

  tam_pkg::tam_chan_vec_t alarm1_gate_r;
  tam_pkg::tam_chan_vec_t alarm2_gate_r;
  tam_pkg::tam_chan_vec_t alarm3_gate_r;
  logic [6:0]             local_thr_r;
  tam_pkg::tam_byte_t     rem1_thr_a_r;
  tam_pkg::tam_byte_t     rem2_thr_a_r;
  tam_pkg::tam_byte_t     rem3_thr_r;
  tam_pkg::tam_byte_t     rem4_thr_r;
  tam_pkg::tam_byte_t     rem1_thr_b_r;
  tam_pkg::tam_byte_t     rem2_thr_b_r;
  logic [4:0]             hyst_r;
  tam_pkg::tam_byte_t     reg_rdata_nxt;
  tam_pkg::tam_byte_t     local_thr_full;
  tam_pkg::tam_byte_t     chan_temp [5];
  logic [2:0][4:0]        over_flag;
  logic                   alarm_out_1_n_nxt;
  logic                   alarm_out_2_n_nxt;
  logic                   alarm_out_3_n_nxt;

  // Bit 7 is hard zero, so the local limit never exceeds 127
  assign local_thr_full = {1'b0, local_thr_r};

  assign chan_temp[`TAM_LOCAL_BIT]   = local_temp;
  assign chan_temp[`TAM_REMOTE1_BIT] = remote1_temp;
  assign chan_temp[`TAM_REMOTE2_BIT] = remote2_temp;
  assign chan_temp[`TAM_REMOTE3_BIT] = remote3_temp;
  assign chan_temp[`TAM_REMOTE4_BIT] = remote4_temp;

  // Gate registers: only bits 4..0 are stored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alarm1_gate_r <= `TAM_ALARM1_GATE_RST;
      alarm2_gate_r <= `TAM_ALARM2_GATE_RST;
      alarm3_gate_r <= `TAM_ALARM3_GATE_RST;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `TAM_ALARM1_GATE_ADDR: begin
          alarm1_gate_r <= reg_wdata[`TAM_GATE_MSB:0];
        end
        `TAM_ALARM2_GATE_ADDR: begin
          alarm2_gate_r <= reg_wdata[`TAM_GATE_MSB:0];
        end
        `TAM_ALARM3_GATE_ADDR: begin
          alarm3_gate_r <= reg_wdata[`TAM_GATE_MSB:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Threshold registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      local_thr_r  <= `TAM_LOCAL_THR_RST;
      rem1_thr_a_r <= `TAM_REM_THR_A_RST;
      rem2_thr_a_r <= `TAM_REM_THR_A_RST;
      rem3_thr_r   <= `TAM_REM_THR_RST;
      rem4_thr_r   <= `TAM_REM_THR_RST;
      rem1_thr_b_r <= `TAM_REM_THR_RST;
      rem2_thr_b_r <= `TAM_REM_THR_RST;
    end else if (reg_wr_en) begin
      unique case (reg_addr)
        `TAM_LOCAL_THR_ADDR: begin
          local_thr_r <= reg_wdata[`TAM_LOCAL_THR_MSB:0];
        end
        `TAM_REM1_THR_A_ADDR: begin
          rem1_thr_a_r <= reg_wdata;
        end
        `TAM_REM2_THR_A_ADDR: begin
          rem2_thr_a_r <= reg_wdata;
        end
        `TAM_REM3_THR_ADDR: begin
          rem3_thr_r <= reg_wdata;
        end
        `TAM_REM4_THR_ADDR: begin
          rem4_thr_r <= reg_wdata;
        end
        `TAM_REM1_THR_B_ADDR: begin
          rem1_thr_b_r <= reg_wdata;
        end
        `TAM_REM2_THR_B_ADDR: begin
          rem2_thr_b_r <= reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // Shared hysteresis
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hyst_r <= `TAM_HYST_RST;
    end else if (reg_wr_en && reg_addr == `TAM_HYST_ADDR) begin
      hyst_r <= reg_wdata[`TAM_HYST_MSB:0];
    end
  end

  // Read data; unmapped addresses read zero
  always_comb begin
    reg_rdata_nxt = 8'h00;
    unique case (reg_addr)
      `TAM_ALARM1_GATE_ADDR: reg_rdata_nxt = {3'h0, alarm1_gate_r};
      `TAM_ALARM2_GATE_ADDR: reg_rdata_nxt = {3'h0, alarm2_gate_r};
      `TAM_ALARM3_GATE_ADDR: reg_rdata_nxt = {3'h0, alarm3_gate_r};
      `TAM_LOCAL_THR_ADDR:   reg_rdata_nxt = local_thr_full;
      `TAM_REM1_THR_A_ADDR:  reg_rdata_nxt = rem1_thr_a_r;
      `TAM_REM2_THR_A_ADDR:  reg_rdata_nxt = rem2_thr_a_r;
      `TAM_REM3_THR_ADDR:    reg_rdata_nxt = rem3_thr_r;
      `TAM_REM4_THR_ADDR:    reg_rdata_nxt = rem4_thr_r;
      `TAM_REM1_THR_B_ADDR:  reg_rdata_nxt = rem1_thr_b_r;
      `TAM_REM2_THR_B_ADDR:  reg_rdata_nxt = rem2_thr_b_r;
      `TAM_HYST_ADDR:        reg_rdata_nxt = {3'h0, hyst_r};
      default:               reg_rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_rdata_r    <= 8'h00;
      reg_rd_valid_r <= 1'b0;
    end else begin
      reg_rd_valid_r <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_r <= reg_rdata_nxt;
      end
    end
  end

  // One flag per alarm and channel; set A limits only for alarm 1
  for (genvar a = 0; a < 3; a++) begin : g_alarm
    for (genvar c = 0; c < 5; c++) begin : g_chan
      tam_pkg::tam_byte_t limit_sel;
      if (c == `TAM_LOCAL_BIT) begin : g_loc
        assign limit_sel = local_thr_full;
      end else if (c == `TAM_REMOTE1_BIT) begin : g_r1
        assign limit_sel = (a == 0) ? rem1_thr_a_r : rem1_thr_b_r;
      end else if (c == `TAM_REMOTE2_BIT) begin : g_r2
        assign limit_sel = (a == 0) ? rem2_thr_a_r : rem2_thr_b_r;
      end else if (c == `TAM_REMOTE3_BIT) begin : g_r3
        assign limit_sel = rem3_thr_r;
      end else begin : g_r4
        assign limit_sel = rem4_thr_r;
      end
      tam_over_flag u_flag (
        .ref_clk (ref_clk),
        .reset   (reset),
        .update  (conv_done[c]),
        .reading (chan_temp[c]),
        .limit   (limit_sel),
        .hyst    (hyst_r),
        .over_r  (over_flag[a][c])
      );
    end
  end

  assign alarm1_over_flags = over_flag[0];
  assign alarm2_over_flags = over_flag[1];
  assign alarm3_over_flags = over_flag[2];

  // Gate then OR; low means alarm asserted
  assign alarm_out_1_n_nxt = ~|(over_flag[0] & ~alarm1_gate_r);
  assign alarm_out_2_n_nxt = ~|(over_flag[1] & ~alarm2_gate_r);
  assign alarm_out_3_n_nxt = ~|(over_flag[2] & ~alarm3_gate_r);

  // Registered so the pins never glitch while a gate is rewritten
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      alarm_out_1_n_r <= 1'b1;
      alarm_out_2_n_r <= 1'b1;
      alarm_out_3_n_r <= 1'b1;
    end else begin
      alarm_out_1_n_r <= alarm_out_1_n_nxt;
      alarm_out_2_n_r <= alarm_out_2_n_nxt;
      alarm_out_3_n_r <= alarm_out_3_n_nxt;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  alarm1_gating_a: assert property (
    ##1 alarm_out_1_n_r == ~|($past(over_flag[0]) & $past(alarm1_gate_r)
                              ^ $past(over_flag[0]))
  ) else $error("alarm 1 does not follow its gated flags");

  alarm2_gating_a: assert property (
    (|(over_flag[1] & ~alarm2_gate_r)) |=> !alarm_out_2_n_r
  ) else $error("alarm 2 not asserted for an unmasked flag");

  alarm3_gating_a: assert property (
    ((over_flag[2] & ~alarm3_gate_r) == 5'h00) |=> alarm_out_3_n_r
  ) else $error("alarm 3 asserted with every flag masked");

  gate_write_a: assert property (
    (reg_wr_en && reg_addr == `TAM_ALARM2_GATE_ADDR)
      |=> alarm2_gate_r == $past(reg_wdata[4:0])
  ) else $error("gate register did not take written bits");

  gate_rsvd_read_a: assert property (
    (reg_rd_en && (reg_addr == `TAM_ALARM1_GATE_ADDR ||
                   reg_addr == `TAM_ALARM3_GATE_ADDR))
      |=> reg_rd_valid_r && reg_rdata_r[7:5] == 3'h0
  ) else $error("gate reserved bits read nonzero");

  local_thr_write_a: assert property (
    (reg_wr_en && reg_addr == `TAM_LOCAL_THR_ADDR)
      |=> local_thr_r == $past(reg_wdata[6:0])
  ) else $error("local threshold write lost");

  local_bit7_a: assert property (
    (reg_rd_en && reg_addr == `TAM_LOCAL_THR_ADDR) |=> !reg_rdata_r[7]
  ) else $error("local threshold bit 7 read as one");

  // The serial engine leaves one idle cycle between a write and a read
  remote_write_a: assert property (
    (reg_wr_en && reg_addr == `TAM_REM4_THR_ADDR) ##1 !reg_wr_en
      ##1 (reg_rd_en && reg_addr == `TAM_REM4_THR_ADDR && !reg_wr_en)
      |=> reg_rdata_r == $past(reg_wdata, 3)
  ) else $error("remote threshold readback mismatch");

  local_set_a: assert property (
    (conv_done[0] && local_temp >= local_thr_full) |=> over_flag[2][0]
  ) else $error("local flag not set at limit");

  set_a_limit_a: assert property (
    (conv_done[1] && remote1_temp >= rem1_thr_a_r) |=> over_flag[0][1]
  ) else $error("remote 1 alarm 1 flag ignores set A limit");

  set_b_limit_a: assert property (
    (conv_done[2] && remote2_temp >= rem2_thr_b_r)
      |=> over_flag[1][2] && over_flag[2][2]
  ) else $error("remote 2 set B limit not applied to alarms 2 and 3");

  shared_limit_a: assert property (
    over_flag[0][3] == over_flag[1][3] && over_flag[1][4] == over_flag[2][4]
  ) else $error("shared-limit channels disagree between alarms");

  hyst_clear_a: assert property (
    (conv_done[3] && ({1'b0, remote3_temp} + {4'h0, hyst_r})
                     < {1'b0, rem3_thr_r}) |=> !over_flag[0][3]
  ) else $error("flag not cleared below limit minus hysteresis");

  hyst_hold_a: assert property (
    (conv_done[4] && remote4_temp < rem4_thr_r &&
     ({1'b0, remote4_temp} + {4'h0, hyst_r}) >= {1'b0, rem4_thr_r})
      |=> $stable(over_flag[1][4])
  ) else $error("flag changed inside the hysteresis band");

  no_update_hold_a: assert property (
    !conv_done[0] |=> $stable(over_flag[0][0])
  ) else $error("local flag changed without a new conversion");

  alarm_release_a: assert property (
    $rose(alarm_out_1_n_r) |-> $past((over_flag[0] & ~alarm1_gate_r) == 5'h00)
  ) else $error("alarm 1 released while an unmasked flag was set");

  hyst_write_a: assert property (
    (reg_wr_en && reg_addr == `TAM_HYST_ADDR)
      |=> hyst_r == $past(reg_wdata[4:0])
  ) else $error("hysteresis write lost");

  gate1_hold_a: assert property (
    !(reg_wr_en && reg_addr == `TAM_ALARM1_GATE_ADDR)
      |=> $stable(alarm1_gate_r)
  ) else $error("alarm 1 gate changed without a write");

  gate3_write_a: assert property (
    (reg_wr_en && reg_addr == `TAM_ALARM3_GATE_ADDR)
      |=> alarm3_gate_r == $past(reg_wdata[4:0])
  ) else $error("alarm 3 gate write lost its writable bits");

  alarm1_fire_c: cover property (
    !alarm_out_1_n_r ##[1:20] alarm_out_1_n_r
  );

  masked_event_c: cover property (
    over_flag[2][0] && alarm3_gate_r[0] && alarm_out_3_n_r
  );

  hyst_band_c: cover property (
    over_flag[1][4] && conv_done[4] && remote4_temp < rem4_thr_r
  );

  set_a_split_c: cover property (
    over_flag[0][1] && !over_flag[1][1]
  );

  hyst_write_c: cover property (
    reg_wr_en && reg_addr == `TAM_HYST_ADDR
  );

endmodule

`default_nettype wire

// >>> rtl/tam_consts.svh
`ifndef TAM_CONSTS_SVH
`define TAM_CONSTS_SVH

// Command-byte addresses
`define TAM_ALARM1_GATE_ADDR   8'h0c
`define TAM_ALARM2_GATE_ADDR   8'h0d
`define TAM_ALARM3_GATE_ADDR   8'h0e
`define TAM_LOCAL_THR_ADDR     8'h40
`define TAM_REM1_THR_A_ADDR    8'h41
`define TAM_REM2_THR_A_ADDR    8'h42
`define TAM_REM3_THR_ADDR      8'h43
`define TAM_REM4_THR_ADDR      8'h44
`define TAM_REM1_THR_B_ADDR    8'h49
`define TAM_REM2_THR_B_ADDR    8'h4a
`define TAM_HYST_ADDR          8'h5a

// Reset values
`define TAM_ALARM1_GATE_RST    5'h19
`define TAM_ALARM2_GATE_RST    5'h00
`define TAM_ALARM3_GATE_RST    5'h07
`define TAM_LOCAL_THR_RST      7'h55
`define TAM_REM_THR_A_RST      8'h6e
`define TAM_REM_THR_RST        8'h55
`define TAM_HYST_RST           5'h0a

// Field positions inside every gate register, then local threshold and hysteresis MSBs
`define TAM_LOCAL_BIT          0
`define TAM_REMOTE1_BIT        1
`define TAM_REMOTE2_BIT        2
`define TAM_REMOTE3_BIT        3
`define TAM_REMOTE4_BIT        4
`define TAM_GATE_MSB           4
`define TAM_LOCAL_THR_MSB      6
`define TAM_HYST_MSB           4

`endif

// >>> rtl/tam_pkg.sv
package tam_pkg;

  typedef logic [7:0] tam_byte_t;
  typedef logic [4:0] tam_chan_vec_t;

endpackage

// >>> rtl/tam_over_flag.sv
`timescale 1ns/10ps
`default_nettype none

// One channel-versus-limit flag with falling-temperature hysteresis
module tam_over_flag (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Comparison inputs
  input  wire logic             update,
  input  wire tam_pkg::tam_byte_t reading,
  input  wire tam_pkg::tam_byte_t limit,
  input  wire logic [4:0]       hyst,
  // Flag
  output logic                  over_r
);

  logic [8:0] rising_sum;
  logic       over_nxt;

  // Sum form avoids underflow of limit minus hysteresis
  assign rising_sum = {1'b0, reading} + {4'h0, hyst};

  always_comb begin
    over_nxt = over_r;
    if (update) begin
      if (reading >= limit) begin
        over_nxt = 1'b1;
      end else if (rising_sum < {1'b0, limit}) begin
        over_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      over_r <= 1'b0;
    end else begin
      over_r <= over_nxt;
    end
  end

endmodule

`default_nettype wire

// >>> bench/tam_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Serial-engine side of the register port: one byte per strobe
module tam_host_model (
  // Clock
  input  wire logic               ref_clk,
  // Register port
  output logic                    reg_wr_en,
  output logic                    reg_rd_en,
  output tam_pkg::tam_byte_t      reg_addr,
  output tam_pkg::tam_byte_t      reg_wdata,
  input  wire tam_pkg::tam_byte_t reg_rdata_r,
  input  wire logic               reg_rd_valid_r
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // Released lines show the inverse so a stale value is never reused
  task automatic wr(input tam_pkg::tam_byte_t a, input tam_pkg::tam_byte_t d);
    @(negedge ref_clk);
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic rd(input tam_pkg::tam_byte_t a,
                    output tam_pkg::tam_byte_t d, output logic ok);
    int n;
    @(negedge ref_clk);
    reg_rd_en = 1'b1;
    reg_addr  = a;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    ok = 1'b0;
    d  = 8'h00;
    for (n = 0; n < 4 && !ok; n++) begin
      if (reg_rd_valid_r === 1'b1) begin
        ok = 1'b1;
        d  = reg_rdata_r;
      end else begin
        @(negedge ref_clk);
      end
    end
  endtask
endmodule

`default_nettype wire

// >>> bench/thermal_alarm_mask_limits_bench.sv
`timescale 1ns/10ps
`default_nettype none

module thermal_alarm_mask_limits_bench;
  typedef struct {
    tam_pkg::tam_byte_t a, r, w, e;
  } tam_row_t;

  logic                   ref_clk;
  logic                   reset;
  wire logic              wr_en;
  wire logic              rd_en;
  tam_pkg::tam_byte_t     addr;
  tam_pkg::tam_byte_t     wdata;
  tam_pkg::tam_byte_t     rdata;
  logic                   rd_valid;
  tam_pkg::tam_chan_vec_t conv_done;
  tam_pkg::tam_byte_t     temps [5];
  tam_pkg::tam_chan_vec_t f1, f2, f3;
  logic                   a1, a2, a3;
  int                     bad_count;
  int                     samples_checked;
  tam_row_t               rows [12];

  tam_host_model host_u (.ref_clk(ref_clk), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_r(rdata), .reg_rd_valid_r(rd_valid));

  tam_top dut_u (.ref_clk(ref_clk), .reset(reset), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wdata(wdata),
    .reg_rdata_r(rdata), .reg_rd_valid_r(rd_valid),
    .conv_done(conv_done), .local_temp(temps[0]),
    .remote1_temp(temps[1]), .remote2_temp(temps[2]),
    .remote3_temp(temps[3]), .remote4_temp(temps[4]),
    .alarm1_over_flags(f1), .alarm2_over_flags(f2),
    .alarm3_over_flags(f3), .alarm_out_1_n_r(a1),
    .alarm_out_2_n_r(a2), .alarm_out_3_n_r(a3));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string n, input tam_pkg::tam_byte_t s,
                     input tam_pkg::tam_byte_t e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic rchk(input tam_pkg::tam_byte_t a,
                      input tam_pkg::tam_byte_t e);
    tam_pkg::tam_byte_t v;
    logic ok;
    host_u.rd(a, v, ok);
    chk("read_valid", {7'h00, ok}, 8'h01);
    if (ok !== 1'b1) begin
      print_verdict();
    end
    chk("read_data", v, e);
  endtask

  // Pins expected as {alarm3, alarm2, alarm1}, high means quiet
  task automatic fchk(input logic [4:0] e1, input logic [4:0] e2,
                      input logic [4:0] e3, input logic [2:0] p);
    chk("flags1", {3'h0, f1}, {3'h0, e1});
    chk("flags2", {3'h0, f2}, {3'h0, e2});
    chk("flags3", {3'h0, f3}, {3'h0, e3});
    chk("pins", {5'h00, a3, a2, a1}, {5'h00, p});
  endtask

  task automatic conv(input int ch, input tam_pkg::tam_byte_t v);
    @(negedge ref_clk);
    temps[ch] = v;
    conv_done = 5'h01 << ch;
    @(negedge ref_clk);
    conv_done = 5'h00;
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic gwr(input tam_pkg::tam_byte_t a, input tam_pkg::tam_byte_t d);
    host_u.wr(a, d);
    repeat (2) @(negedge ref_clk);
  endtask

  initial begin
    bad_count = 0;
    samples_checked = 0;
    reset = 1'b1;
    conv_done = 5'h00;
    foreach (temps[i]) temps[i] = 8'h00;
    rows = '{'{8'h0c, 8'h19, 8'hff, 8'h1f}, '{8'h0d, 8'h00, 8'he5, 8'h05},
             '{8'h0e, 8'h07, 8'hff, 8'h1f}, '{8'h40, 8'h55, 8'hff, 8'h7f},
             '{8'h41, 8'h6e, 8'hff, 8'hff}, '{8'h42, 8'h6e, 8'h80, 8'h80},
             '{8'h43, 8'h55, 8'ha5, 8'ha5}, '{8'h44, 8'h55, 8'h5a, 8'h5a},
             '{8'h49, 8'h55, 8'h01, 8'h01}, '{8'h4a, 8'h55, 8'hfe, 8'hfe},
             '{8'h5a, 8'h0a, 8'hff, 8'h1f}, '{8'h20, 8'h00, 8'hff, 8'h00}};
    repeat (16) @(negedge ref_clk);
    reset = 1'b0;
    fchk(5'h00, 5'h00, 5'h00, 3'h7);
    foreach (rows[i]) begin
      rchk(rows[i].a, rows[i].r);
      host_u.wr(rows[i].a, rows[i].w);
      rchk(rows[i].a, rows[i].e);
    end
    host_u.wr(8'h0c, 8'h00);
    host_u.wr(8'h0d, 8'h00);
    host_u.wr(8'h0e, 8'h02);
    host_u.wr(8'h41, 8'h50);
    host_u.wr(8'h49, 8'h40);
    host_u.wr(8'h44, 8'hff);
    host_u.wr(8'h5a, 8'h0a);
    // Bit 7 dropped, so the local limit becomes 0x30
    host_u.wr(8'h40, 8'hb0);
    conv(1, 8'h48);
    fchk(5'h00, 5'h02, 5'h02, 3'h5);
    conv(1, 8'h50);
    fchk(5'h02, 5'h02, 5'h02, 3'h4);
    conv(1, 8'h46);
    fchk(5'h02, 5'h02, 5'h02, 3'h4);
    conv(1, 8'h45);
    fchk(5'h00, 5'h02, 5'h02, 3'h5);
    gwr(8'h0d, 8'h02);
    fchk(5'h00, 5'h02, 5'h02, 3'h7);
    conv(0, 8'h30);
    fchk(5'h01, 5'h03, 5'h03, 3'h0);
    @(negedge ref_clk);
    temps[0] = 8'h00;
    repeat (3) @(negedge ref_clk);
    fchk(5'h01, 5'h03, 5'h03, 3'h0);
    conv(4, 8'hfe);
    fchk(5'h01, 5'h03, 5'h03, 3'h0);
    conv(4, 8'hff);
    fchk(5'h11, 5'h13, 5'h13, 3'h0);
    gwr(8'h0c, 8'h11);
    fchk(5'h11, 5'h13, 5'h13, 3'h1);
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    fchk(5'h00, 5'h00, 5'h00, 3'h7);
    reset = 1'b0;
    rchk(8'h0c, 8'h19);
    rchk(8'h44, 8'h55);
    print_verdict();
  end
endmodule

`default_nettype wire
